// ### logic/dcs_pkg.sv
// package of constants for the drive control word sequencer
// Notes on behaviour
// - check mode, selector off: on+run checks all
// - check outcome stored in result word
// - check end returns service mode to normal
// - check end switches drive off
// - selector set: only that one pulse fires
// - back to normal clears pulse selector
// - firmware version and type readable
// - commands from word, status word reports
// - bit 2 cleared means emergency stop, acted on in run state only
// - contactor closes at on only in contactor mode on
// - on and run taken on rising edges
// - shared source: one command gives on+run
// - on removed: stop by mode, open contactor
// - sequencing state in drive state word
// - 04f6 resets trip, 0474 inhibits start
package dcs_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_USED = 8'h04;
    localparam logic [7:0] REG_CFG = 8'h08;
    localparam logic [7:0] REG_SVC = 8'h0c;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam logic [7:0] REG_DSTATE = 8'h14;
    localparam logic [7:0] REG_DIAG = 8'h18;
    localparam logic [7:0] REG_FWVER = 8'h1c;
    localparam logic [7:0] REG_FWTYPE = 8'h20;
    localparam logic [7:0] REG_IRQ_ST = 8'h24;
    localparam logic [7:0] REG_IRQ_MSK = 8'h28;
    // command word bit positions
    localparam int B_ON = 0;
    localparam int B_COAST_N = 1;
    localparam int B_ESTOP_N = 2;
    localparam int B_RUN = 3;
    localparam int B_RESET = 7;
    localparam int B_REMOTE = 10;
    // reset values
    localparam logic [15:0] CMD_RST = 16'h0476;
    localparam logic [6:0] CFG_RST = 7'h00;
    // arbitrary identification values
    localparam logic [15:0] FW_VERSION = 16'h0100;
    localparam logic [15:0] FW_TYPE = 16'h0001;
    // contactor modes and stop modes
    localparam logic [1:0] CONT_ON = 2'h0;
    localparam logic [1:0] CONT_ON_RUN = 2'h1;
    localparam logic [1:0] STOP_RAMP = 2'h0;
    localparam logic [1:0] STOP_TORQ = 2'h1;
    localparam logic [1:0] STOP_COAST = 2'h2;
    // number of firing pulses (v11..v16, v21..v26)
    localparam int NPULSE = 12;
    // timing
    localparam int CLK_NS = 10;
    localparam int FIRE_NS = 10000;
    localparam int RAMP_NS = 20000;
    localparam int TORQ_NS = 5000;
    localparam int ESTOP_NS = 2000;
    localparam logic [11:0] FIRE_CYC = 12'((FIRE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] RAMP_CYC = 12'((RAMP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] TORQ_CYC = 12'((TORQ_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [11:0] ESTOP_CYC = 12'((ESTOP_NS + CLK_NS - 1) / CLK_NS);
    // sequencer states, one-hot
    typedef enum logic [6:0] {
        ST_OFF = 7'h01,
        ST_RDY_ON = 7'h02,
        ST_RUN = 7'h04,
        ST_STOP = 7'h08,
        ST_ESTOP = 7'h10,
        ST_CHECK = 7'h20,
        ST_PULSE = 7'h40
    } dcs_state_t;
endpackage

// ### logic/dcs_sequencer.sv
// drive control word sequencer with apb registers and thyristor diagnosis
`timescale 1ns/1ps
module dcs_sequencer (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // hardware command word and conduction feedback pins
    input wire logic [15:0] pin_cmd_word_i,
    input wire logic [dcs_pkg::NPULSE-1:0] cond_fb_i,
    // power stage
    output logic contactor_close_o,
    output logic [dcs_pkg::NPULSE-1:0] fire_o,
    // interrupt
    output logic irq_o
);
    import dcs_pkg::*;

    // one-hot firing vector for a pulse index
    function automatic logic [NPULSE-1:0] pulse_bit(input logic [3:0] idx);
        pulse_bit = NPULSE'(1) << idx;
    endfunction

    // stop duration for the configured stop mode
    function automatic logic [11:0] stop_len(input logic [1:0] mode);
        case (mode)
            STOP_RAMP: stop_len = RAMP_CYC;
            STOP_TORQ: stop_len = TORQ_CYC;
            default: stop_len = 12'h001;
        endcase
    endfunction

    logic [15:0] cmd_ff; // software command word
    logic [6:0] cfg_ff; // [1:0] contactor, [3:2] stop, 4 same source, 5 pin source
    logic svc_mode_ff; // thyristor_check_mode when set
    logic [3:0] pulse_sel_ff; // 0 off, 1..12 selects one pulse
    logic [NPULSE-1:0] diag_ff; // check outcome, one bit per failed pulse
    logic [NPULSE-1:0] scratch_ff; // outcome being gathered
    logic [3:0] irq_st_ff; // sticky events
    logic [3:0] irq_msk_ff; // event enables
    logic [15:0] pin_s1_ff; // first synchroniser stage
    logic [15:0] pin_s2_ff;
    logic [NPULSE-1:0] fb_s1_ff;
    logic [NPULSE-1:0] fb_s2_ff;
    logic on_prev_ff; // previous levels for edge detect
    logic run_prev_ff;
    logic rst_prev_ff;
    logic trip_ff; // emergency stop latched until reset
    logic pulse_done_ff; // single pulse already issued
    dcs_state_t state_ff;
    dcs_state_t nxt_state;
    logic [11:0] tmr_ff;
    logic [3:0] idx_ff; // pulse under check
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic cont_ff;
    logic [NPULSE-1:0] fire_ff;
    logic irq_ff;

    // decoded command levels and events
    logic [15:0] used_word;
    logic remote;
    logic on_lvl;
    logic run_lvl;
    logic on_rise;
    logic run_rise;
    logic start_ev;
    logic check_end;
    logic pulse_end;
    logic bus_wr;
    logic invalid_ev;
    logic [3:0] irq_set;
    logic [15:0] status_word;

    assign bus_wr = psel_i & penable_i & pready_ff & pwrite_i;
    assign used_word = cfg_ff[5] ? pin_s2_ff : cmd_ff;
    assign remote = used_word[B_REMOTE];
    // shared source: the run bit also carries on
    assign on_lvl = used_word[B_ON] | (cfg_ff[4] & used_word[B_RUN]);
    assign run_lvl = used_word[B_RUN];
    assign on_rise = on_lvl & !on_prev_ff;
    assign run_rise = run_lvl & !run_prev_ff;
    // start of a diagnosis needs both levels, one of them freshly risen
    assign start_ev = (on_rise & run_lvl) | (run_rise & on_lvl);
    assign check_end = (state_ff == ST_CHECK) && (tmr_ff == FIRE_CYC - 12'h001)
        && (idx_ff == 4'(NPULSE - 1));
    assign pulse_end = (state_ff == ST_PULSE) && (tmr_ff == FIRE_CYC - 12'h001);
    // run without on while off is out of order
    assign invalid_ev = (state_ff == ST_OFF) && run_rise && !on_lvl && remote;

    // event sources: check done, emergency stop, drive off, bad command
    assign irq_set[0] = check_end;
    assign irq_set[1] = (state_ff == ST_RUN) && (nxt_state == ST_ESTOP);
    assign irq_set[2] = (state_ff != ST_OFF) && (nxt_state == ST_OFF);
    assign irq_set[3] = invalid_ev;

    // status word: handshake and interlocks
    always_comb begin
        status_word = 16'h0000;
        status_word[0] = (state_ff != ST_OFF) && !trip_ff; // ready for on
        status_word[1] = (state_ff == ST_RDY_ON) || (state_ff == ST_RUN); // ready to run
        status_word[2] = (state_ff == ST_RUN); // running with reference
        status_word[3] = trip_ff; // tripped
        status_word[4] = used_word[B_COAST_N];
        status_word[5] = used_word[B_ESTOP_N];
        status_word[6] = !used_word[B_COAST_N] || trip_ff;
        status_word[7] = svc_mode_ff;
        status_word[8] = cont_ff;
        status_word[9] = remote;
    end

    // pin synchronisers, second stage is the only reader of the first
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pin_s1_ff <= 16'h0000;
            pin_s2_ff <= 16'h0000;
            fb_s1_ff <= '0;
            fb_s2_ff <= '0;
        end else begin
            pin_s1_ff <= pin_cmd_word_i;
            pin_s2_ff <= pin_s1_ff;
            fb_s1_ff <= cond_fb_i;
            fb_s2_ff <= fb_s1_ff;
        end
    end

    // edge history of the command levels
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            on_prev_ff <= 1'b0;
            run_prev_ff <= 1'b0;
            rst_prev_ff <= 1'b0;
        end else begin
            on_prev_ff <= on_lvl;
            run_prev_ff <= run_lvl;
            rst_prev_ff <= used_word[B_RESET];
        end
    end

    // sequencer next state; the remote bit gates only starts from off
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_OFF: begin
                if (remote && used_word[B_COAST_N] && !trip_ff) begin
                    if (svc_mode_ff && start_ev) begin
                        // zero selector checks all, otherwise one pulse
                        nxt_state = (pulse_sel_ff == 4'h0) ? ST_CHECK : ST_PULSE;
                    end else if (!svc_mode_ff && cfg_ff[4] && start_ev) begin
                        nxt_state = ST_RUN;
                    end else if (!svc_mode_ff && on_rise && !run_lvl) begin
                        nxt_state = ST_RDY_ON;
                    end
                end
            end
            ST_RDY_ON: begin
                if (!used_word[B_COAST_N] || !on_lvl) begin
                    nxt_state = ST_OFF;
                end else if (run_rise) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!used_word[B_COAST_N]) begin
                    nxt_state = ST_OFF; // coast stop
                end else if (!used_word[B_ESTOP_N]) begin
                    nxt_state = ST_ESTOP;
                end else if (!on_lvl) begin
                    nxt_state = ST_STOP;
                end else if (!run_lvl) begin
                    nxt_state = ST_RDY_ON;
                end
            end
            ST_STOP: begin
                // contactor opens once the stop time has run
                if (!used_word[B_COAST_N] || (tmr_ff >= stop_len(cfg_ff[3:2]) - 12'h001)) begin
                    nxt_state = ST_OFF;
                end
            end
            ST_ESTOP: begin
                if (tmr_ff == ESTOP_CYC - 12'h001) begin
                    nxt_state = ST_OFF;
                end
            end
            ST_CHECK: begin
                // off at the end even if on and run remain
                if (check_end || !used_word[B_COAST_N]) begin
                    nxt_state = ST_OFF;
                end
            end
            ST_PULSE: begin
                if (!on_lvl || !run_lvl) begin
                    nxt_state = ST_OFF;
                end
            end
            default: nxt_state = ST_OFF;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_ff <= ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // state timer, restarts on every state change or checked pulse
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            tmr_ff <= 12'h000;
            idx_ff <= 4'h0;
        end else if (nxt_state != state_ff) begin
            tmr_ff <= 12'h000;
            idx_ff <= 4'h0;
        end else if (state_ff == ST_CHECK && tmr_ff == FIRE_CYC - 12'h001) begin
            tmr_ff <= 12'h000;
            idx_ff <= idx_ff + 4'h1;
        end else if (tmr_ff != 12'hfff) begin
            tmr_ff <= tmr_ff + 12'h001;
        end
    end

    // check outcome: a pulse without conduction feedback is marked failed
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            scratch_ff <= '0;
            diag_ff <= '0;
        end else if (state_ff == ST_CHECK && tmr_ff == FIRE_CYC - 12'h001) begin
            scratch_ff <= scratch_ff | (fb_s2_ff[idx_ff] ? '0 : pulse_bit(idx_ff));
            if (check_end) begin
                diag_ff <= scratch_ff | (fb_s2_ff[idx_ff] ? '0 : pulse_bit(idx_ff));
            end
        end else if (state_ff != ST_CHECK) begin
            scratch_ff <= '0;
        end
    end

    // trip latch: set by emergency stop, cleared by reset edge
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            trip_ff <= 1'b0;
        end else if (state_ff == ST_ESTOP) begin
            trip_ff <= 1'b1;
        end else if (remote && used_word[B_RESET] && !rst_prev_ff) begin
            trip_ff <= 1'b0;
        end
    end

    // power stage outputs; contactor stays open in a single pulse test
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cont_ff <= 1'b0;
            fire_ff <= '0;
            pulse_done_ff <= 1'b0;
        end else begin
            case (nxt_state)
                ST_RDY_ON: cont_ff <= (cfg_ff[1:0] == CONT_ON);
                ST_RUN, ST_STOP, ST_ESTOP: cont_ff <= (cfg_ff[1:0] == CONT_ON) ||
                    (cfg_ff[1:0] == CONT_ON_RUN);
                ST_CHECK: cont_ff <= 1'b1;
                default: cont_ff <= 1'b0;
            endcase
            if (state_ff == ST_CHECK) begin
                fire_ff <= pulse_bit(idx_ff);
            end else if (state_ff == ST_PULSE && !pulse_done_ff) begin
                fire_ff <= pulse_bit(pulse_sel_ff - 4'h1);
            end else begin
                fire_ff <= '0;
            end
            if (state_ff != ST_PULSE) begin
                pulse_done_ff <= 1'b0;
            end else if (pulse_end) begin
                pulse_done_ff <= 1'b1; // one pulse only
            end
        end
    end

    // software command word and configuration
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cmd_ff <= CMD_RST;
            cfg_ff <= CFG_RST;
        end else if (bus_wr) begin
            if (paddr_i == REG_CMD) begin
                cmd_ff <= pwdata_i[15:0];
            end
            if (paddr_i == REG_CFG) begin
                cfg_ff <= pwdata_i[6:0];
            end
        end
    end

    // service mode and pulse selector; hardware clear follows check end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            svc_mode_ff <= 1'b0;
            pulse_sel_ff <= 4'h0;
        end else if (check_end) begin
            svc_mode_ff <= 1'b0;
        end else if (bus_wr && paddr_i == REG_SVC) begin
            svc_mode_ff <= pwdata_i[0];
            // out-of-range selector falls back to off
            if (!pwdata_i[0]) begin
                pulse_sel_ff <= 4'h0;
            end else if (pwdata_i[7:4] <= 4'(NPULSE)) begin
                pulse_sel_ff <= pwdata_i[7:4];
            end else begin
                pulse_sel_ff <= 4'h0;
            end
        end
    end

    // interrupt status, mask and level output; set wins over clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_st_ff <= 4'h0;
            irq_msk_ff <= 4'h0;
            irq_ff <= 1'b0;
        end else begin
            if (bus_wr && paddr_i == REG_IRQ_ST) begin
                irq_st_ff <= (irq_st_ff & ~pwdata_i[3:0]) | irq_set;
            end else begin
                irq_st_ff <= irq_st_ff | irq_set;
            end
            if (bus_wr && paddr_i == REG_IRQ_MSK) begin
                irq_msk_ff <= pwdata_i[3:0];
            end
            irq_ff <= |(irq_st_ff & irq_msk_ff);
        end
    end

    // apb answer: one wait state, unmapped addresses give an error
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else if (psel_i && penable_i && !pready_ff) begin
            pready_ff <= 1'b1;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
            case (paddr_i)
                REG_CMD: prdata_ff <= {16'h0000, cmd_ff};
                REG_USED: prdata_ff <= {16'h0000, used_word};
                REG_CFG: prdata_ff <= {25'h0, cfg_ff};
                REG_SVC: prdata_ff <= {24'h0, pulse_sel_ff, 3'h0, svc_mode_ff};
                REG_STAT: prdata_ff <= {16'h0000, status_word};
                REG_DSTATE: prdata_ff <= {25'h0, state_ff};
                REG_DIAG: prdata_ff <= {20'h0, diag_ff};
                REG_FWVER: prdata_ff <= {16'h0000, FW_VERSION};
                REG_FWTYPE: prdata_ff <= {16'h0000, FW_TYPE};
                REG_IRQ_ST: prdata_ff <= {28'h0, irq_st_ff};
                REG_IRQ_MSK: prdata_ff <= {28'h0, irq_msk_ff};
                default: pslverr_ff <= 1'b1;
            endcase
        end else begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign contactor_close_o = cont_ff;
    assign fire_o = fire_ff;
    assign irq_o = irq_ff;
endmodule // dcs_sequencer

// ### bench/dcs_sequencer_props.sv
// port assertions for the drive control word sequencer
`timescale 1ns/1ps
module dcs_sequencer_props (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // apb answer side
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // power stage and interrupt
    input wire logic contactor_close_o,
    input wire logic [dcs_pkg::NPULSE-1:0] fire_o,
    input wire logic irq_o
);
    import dcs_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    // length of the pulse now firing; zero on a new or absent pulse
    logic [NPULSE-1:0] fire_q_ff;
    logic [11:0] fire_len_ff;
    logic [11:0] nxt_fire_len;
    assign nxt_fire_len = (fire_o == '0 || fire_o != fire_q_ff) ? 12'h000 : fire_len_ff + 12'h001;
    // helper registers, cleared by reset so a stale pulse is not counted
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            fire_q_ff <= '0;
            fire_len_ff <= 12'h000;
        end else begin
            fire_q_ff <= fire_o;
            fire_len_ff <= nxt_fire_len;
        end
    end
    // first access cycle and the one-cycle answer
    sequence seq_first_access;
        psel_i && $rose(penable_i) && !pready_o;
    endsequence
    sequence seq_answer;
        pready_o ##1 !pready_o;
    endsequence
    chk_ready_wait: assert property (seq_first_access |=> seq_answer)
        else $error("pready late or longer than one cycle");
    chk_ready_cause: assert property (pready_o |-> $past(psel_i) && $past(penable_i))
        else $error("pready without an access");
    chk_err_ready: assert property (pslverr_o |-> pready_o)
        else $error("pslverr outside the answer cycle");
    chk_rdata_hold: assert property ($changed(prdata_o) |-> pready_o)
        else $error("read data moved between accesses");
    chk_fire_onehot: assert property ($onehot0(fire_o))
        else $error("more than one firing pulse");
    chk_fire_hold: assert property ($changed(fire_o) && fire_o != '0 |=> $stable(fire_o) [*8])
        else $error("firing pulse too short");
    chk_fire_length: assert property (fire_len_ff <= FIRE_CYC)
        else $error("firing pulse too long");
    chk_reset_quiet: assert property ($fell(rst_i) |-> !contactor_close_o && fire_o == '0 && !irq_o)
        else $error("outputs active after reset");
endmodule // dcs_sequencer_props

bind dcs_sequencer dcs_sequencer_props u_props (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .contactor_close_o(contactor_close_o),
    .fire_o(fire_o),
    .irq_o(irq_o)
);

// ### bench/dcs_thy_model.sv
// thyristor stack model giving conduction feedback per firing pulse
`timescale 1ns/1ps
module dcs_thy_model (
    // clock
    input wire logic ref_clk_i,
    // firing pulses and fault setup
    input wire logic [dcs_pkg::NPULSE-1:0] fire_i,
    input wire logic [dcs_pkg::NPULSE-1:0] dead_i,
    input wire logic slow_i,
    // sensed conduction
    output logic [dcs_pkg::NPULSE-1:0] cond_o
);
    import dcs_pkg::*;
    // delay line; the slow setting answers two cycles later
    logic [NPULSE-1:0] dly_ff [3] = '{default: '0};
    always_ff @(posedge ref_clk_i) begin
        dly_ff[0] <= fire_i & ~dead_i;
        dly_ff[1] <= dly_ff[0];
        dly_ff[2] <= dly_ff[1];
    end
    // a dead device never conducts; an unfired one reads zero
    assign cond_o = slow_i ? dly_ff[2] : dly_ff[0];
endmodule // dcs_thy_model

// ### bench/dcs_sequencer_tb.sv
// self-checking bench for the drive control word sequencer
`timescale 1ns/1ps
module dcs_sequencer_tb;
    import dcs_pkg::*;
    logic ref_clk_i, rst_i, psel_i, penable_i, pwrite_i, slow;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic pready_o, pslverr_o, contactor_close_o, irq_o;
    logic [15:0] pin_cmd_word_i, lfsr;
    logic [NPULSE-1:0] cond_fb_i, fire_o, dead;
    logic [32:0] exp_q [$];
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    // 100 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    dcs_sequencer dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .pin_cmd_word_i(pin_cmd_word_i), .cond_fb_i(cond_fb_i),
        .contactor_close_o(contactor_close_o), .fire_o(fire_o), .irq_o(irq_o));
    dcs_thy_model u_thy (.ref_clk_i(ref_clk_i), .fire_i(fire_o), .dead_i(dead), .slow_i(slow), .cond_o(cond_fb_i));
    // verdict and end of run
    task automatic end_of_test();
        $display("counts: checked %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // compare and count
    task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // 16-bit lfsr step
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // one apb transfer; request held until pready is seen, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do @(posedge ref_clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // note {pslverr, data} first; with the error bit set data is not compared
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // wait for the contactor to open, bounded
    task automatic wait_open(input int lim);
        for (int i = 0; i < lim && contactor_close_o !== 1'b0; i++) @(posedge ref_clk_i);
    endtask
    // watcher: each completed read takes the oldest note
    always @(posedge ref_clk_i) begin
        if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i) begin
            if (exp_q.size() == 0) n_errors++;
            else cmp({pslverr_o, exp_q[0][32] ? 32'h0 : prdata_o}, exp_q.pop_front());
        end
    end
    // hang guard
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc > 40000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        {rst_i, psel_i, penable_i, pwrite_i, slow} = 5'h10;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        pin_cmd_word_i = 16'h0000;
        dead = '0;
        lfsr = 16'h002d;
        repeat (2) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rd(REG_FWVER, {17'h0, FW_VERSION});
        rd(REG_FWTYPE, {17'h0, FW_TYPE});
        rd(REG_CMD, {17'h0, CMD_RST});
        rd(REG_DSTATE, 33'h01);
        rd(8'h2c, 33'h100000000);
        rd(8'h02, 33'h100000000);
        $display("test registers done");
        // pin word without the remote bit is shown but never acts
        wr(REG_CFG, 32'h20);
        repeat (4) begin
            lfsr = step(lfsr);
            pin_cmd_word_i <= lfsr & 16'hfbff;
            repeat (4) @(posedge ref_clk_i);
            rd(REG_USED, {17'h0, lfsr & 16'hfbff});
            rd(REG_DSTATE, 33'h01);
        end
        pin_cmd_word_i <= 16'h0476;
        wr(REG_CFG, 32'h0);
        $display("test pin word done");
        // run without on is refused and raises event 3
        wr(REG_IRQ_MSK, 32'h8);
        wr(REG_CMD, 32'h047e);
        rd(REG_DSTATE, 33'h01);
        rd(REG_IRQ_ST, 33'h8);
        cmp({32'h0, irq_o}, 33'h1);
        wr(REG_IRQ_MSK, 32'h0);
        @(posedge ref_clk_i);
        cmp({32'h0, irq_o}, 33'h0);
        wr(REG_IRQ_ST, 32'h8);
        rd(REG_IRQ_ST, 33'h0);
        wr(REG_CMD, 32'h0476);
        $display("test irq done");
        // start, emergency stop, trip and reset
        wr(REG_CMD, 32'h0477);
        rd(REG_DSTATE, 33'h02);
        cmp({32'h0, contactor_close_o}, 33'h1);
        wr(REG_CMD, 32'h047f);
        rd(REG_DSTATE, 33'h04);
        rd(REG_STAT, 33'h337);
        wr(REG_CMD, 32'h047b);
        rd(REG_DSTATE, 33'h10);
        wait_open(400);
        rd(REG_DSTATE, 33'h01);
        rd(REG_STAT, 33'h258);
        wr(REG_CMD, 32'h0476);
        wr(REG_CMD, 32'h0477);
        rd(REG_DSTATE, 33'h01);
        wr(REG_CMD, 32'h04f7);
        rd(REG_DSTATE, 33'h01);
        wr(REG_CMD, 32'h0476);
        wr(REG_CMD, 32'h0477);
        rd(REG_DSTATE, 33'h02);
        wr(REG_CMD, 32'h047f);
        wr(REG_CMD, 32'h0476);
        rd(REG_DSTATE, 33'h08);
        wait_open(2500);
        rd(REG_DSTATE, 33'h01);
        $display("test sequence done");
        // contactor mode on_run keeps it open until run
        wr(REG_CFG, 32'h1);
        wr(REG_CMD, 32'h0477);
        rd(REG_DSTATE, 33'h02);
        cmp({32'h0, contactor_close_o}, 33'h0);
        wr(REG_CMD, 32'h047f);
        // the contactor changes one edge after the write, on the same edge as the state
        @(posedge ref_clk_i);
        cmp({32'h0, contactor_close_o}, 33'h1);
        wr(REG_CMD, 32'h0476);
        wait_open(2500);
        wr(REG_CFG, 32'h0);
        $display("test contactor mode done");
        // full check, pulse 4 dead, slow feedback
        dead <= 12'h008;
        slow <= 1'b1;
        wr(REG_SVC, 32'h1);
        wr(REG_CMD, 32'h047f);
        rd(REG_DSTATE, 33'h20);
        cmp({32'h0, contactor_close_o}, 33'h1);
        wait_open(13000);
        rd(REG_DIAG, 33'h008);
        rd(REG_SVC, 33'h0);
        rd(REG_DSTATE, 33'h01);
        rd(REG_IRQ_ST, 33'h7);
        wr(REG_CMD, 32'h0476);
        $display("test check done");
        // single pulse 3 selects bit 2
        dead <= '0;
        slow <= 1'b0;
        wr(REG_SVC, 32'h31);
        wr(REG_CMD, 32'h047f);
        rd(REG_DSTATE, 33'h40);
        for (int i = 0; i < 50 && fire_o === '0; i++) @(posedge ref_clk_i);
        cmp({21'h0, fire_o}, 33'h004);
        cmp({32'h0, contactor_close_o}, 33'h0);
        // hold on and run through the whole pulse; it must not come again
        for (int i = 0; i < 1100 && fire_o !== '0; i++) @(posedge ref_clk_i);
        repeat (20) @(posedge ref_clk_i);
        cmp({21'h0, fire_o}, 33'h000);
        rd(REG_DSTATE, 33'h40);
        wr(REG_CMD, 32'h0476);
        wr(REG_SVC, 32'h30);
        rd(REG_SVC, 33'h0);
        $display("test pulse done");
        // shared source: run alone starts, torque stop ends within 500 cycles
        wr(REG_CFG, 32'h14);
        wr(REG_CMD, 32'h047e);
        rd(REG_DSTATE, 33'h04);
        cmp({32'h0, contactor_close_o}, 33'h1);
        wr(REG_CMD, 32'h0476);
        wait_open(600);
        rd(REG_DSTATE, 33'h01);
        wr(REG_CFG, 32'h0);
        $display("test shared source done");
        repeat (2) @(posedge ref_clk_i);
        if (exp_q.size() != 0) n_errors++;
        end_of_test();
    end
endmodule // dcs_sequencer_tb
